// >>> hw/sstf_top.sv
// Serial shift register, transmit queue control and AXI4-Lite register slave
//
// Summary of operation
// - A written word shifts out on later serial clock cycles, MSB first.
// - Each bit shifted out of the top brings one received bit in at bit 0.
// - Serial output is driven only while the transmit drive bit is set.
// - As master, writing the shift register starts a transfer with polarity and phase.
// - As master, any filler word written starts a full transfer to receive.
// - Channel reset low resets both serial channels, FIFO configuration kept.
// - FIFO enable bit selects queue operation; resets to zero.
// - Queue reset low clears the queue pointer and holds it until set.
// - Five-bit read-only queue count, plain binary, zero means empty.
// - Level match sets the queue flag, which stays until software clears it.
// - Writing one to the clear bit clears the flag; the bit reads zero.
// - Queue interrupt enable gates tx_queue_irq, not the flag's masked path to irq; resets to disabled.
// - Level match is count less than or equal to the level, reset zero.
// - A complete character is copied to the receive buffer, setting receive flag.
`timescale 1ns/10ps
module sstf_top
   import sstf_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [31:0] araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        serial_clock_pin_i,
   output logic             serial_clock_pin_o,
   output logic             serial_clock_pin_oe,
   input  wire logic        serial_data_in,
   output logic             serial_data_out,
   output logic             serial_data_out_oe,
   output logic             irq,
   output logic             tx_queue_irq
);
   logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0]        bresp_reg, rresp_reg;
   logic [31:0]       aw_addr_reg, rdata_reg;
   logic [15:0]       w_data_reg;
   logic [1:0]        w_strb_reg;
   sstf_ctrl_s        ctrl_reg;
   sstf_ftx_s         ftx_reg;
   logic [EVT_W-1:0]  mask_reg;
   logic              rx_flag_reg, tx_flag_reg;
   logic [15:0]       rx_buf_reg, shift_reg;
   logic [TXQ_AW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [CNT_W-1:0]  count_reg;
   sstf_state_e       state_reg;
   logic [4:0]        edge_cnt_reg;
   logic [7:0]        div_reg;
   logic              sclk_o_reg, sclk_oe_reg, sdo_reg, sdo_oe_reg, sclk_d_reg;
   logic              irq_reg, tx_irq_reg;
   logic              sclk_s, sdi_s;
   logic [15:0]       mem_rdata, rd_val, ftx_rd;
   logic              rd_ok;

   sstf_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({serial_clock_pin_i, serial_data_in}),
      .q       ({sclk_s, sdi_s})
   );

   // ---------------- AXI4-Lite write channel ----------------
   wire wr_go    = !awready_reg && !wready_reg && !bvalid_reg;
   wire w_shift  = wr_go && sstf_hit(aw_addr_reg, SHIFT_DATA_IDX);
   wire w_ftx    = wr_go && sstf_hit(aw_addr_reg, FIFO_CTRL_IDX);
   wire w_txq    = wr_go && sstf_hit(aw_addr_reg, TXQ_IDX);
   wire w_ctrl   = wr_go && sstf_hit(aw_addr_reg, CTRL_IDX);
   wire w_stat   = wr_go && sstf_hit(aw_addr_reg, STAT_IDX);
   wire w_mask   = wr_go && sstf_hit(aw_addr_reg, MASK_IDX);
   wire w_mapped = w_shift || w_ftx || w_txq || w_ctrl || w_stat || w_mask ||
                   sstf_hit(aw_addr_reg, RXBUF_IDX);
   wire [15:0] ftx_w = sstf_merge(ftx_rd, w_data_reg, w_strb_reg);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         aw_addr_reg <= 32'h0;
         w_data_reg  <= 16'h0;
         w_strb_reg  <= 2'h0;
      end
      else
      begin
         if (awvalid && awready_reg)
         begin
            awready_reg <= 1'b0;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready_reg)
         begin
            wready_reg <= 1'b0;
            w_data_reg <= wdata[15:0];
            w_strb_reg <= wstrb[1:0];
         end
         if (wr_go)
         begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= w_mapped ? RESP_OKAY : RESP_DECERR;
         end
         else if (bvalid_reg && bready)
            bvalid_reg <= 1'b0;
      end
   end

   // ---------------- AXI4-Lite read channel ----------------
   wire ar_take = arvalid && arready_reg;
   wire rd_rx   = ar_take && sstf_hit(araddr, RXBUF_IDX);

   assign ftx_rd = {ftx_reg.chan_rst_n, ftx_reg.fifo_ena, ftx_reg.q_rst_n, count_reg,
                    tx_flag_reg, 1'b0, ftx_reg.irq_en, ftx_reg.level};

   always_comb
   begin
      rd_val = 16'h0;
      rd_ok  = 1'b1;
      if (sstf_hit(araddr, SHIFT_DATA_IDX))
         rd_val = shift_reg;
      else if (sstf_hit(araddr, FIFO_CTRL_IDX))
         rd_val = ftx_rd;
      else if (sstf_hit(araddr, RXBUF_IDX))
         rd_val = rx_buf_reg;
      else if (sstf_hit(araddr, CTRL_IDX))
         rd_val = ctrl_reg;
      else if (sstf_hit(araddr, STAT_IDX))
         rd_val = {14'h0, tx_flag_reg, rx_flag_reg};
      else if (sstf_hit(araddr, MASK_IDX))
         rd_val = {14'h0, mask_reg};
      else if (!sstf_hit(araddr, TXQ_IDX))
         rd_ok = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0;
         rresp_reg   <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= {16'h0, rd_val};
         rresp_reg   <= rd_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (rvalid_reg && rready)
      begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // ---------------- Configuration registers ----------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= CTRL_RESET;
         mask_reg <= '0;
         ftx_reg  <= '{chan_rst_n: FT_RESET[FT_CHRST_BIT], fifo_ena: FT_RESET[FT_ENA_BIT],
                       q_rst_n: FT_RESET[FT_QRST_BIT], irq_en: FT_RESET[FT_IEN_BIT],
                       level: FT_RESET[FT_LVL_MSB:0]};
      end
      else
      begin
         if (w_ctrl)
            ctrl_reg <= sstf_merge(ctrl_reg, w_data_reg, w_strb_reg);
         if (w_mask)
            mask_reg <= w_data_reg[EVT_W-1:0];
         // Channel reset only holds the engine; these bits keep their values
         if (w_ftx)
            ftx_reg <= '{chan_rst_n: ftx_w[FT_CHRST_BIT], fifo_ena: ftx_w[FT_ENA_BIT],
                         q_rst_n: ftx_w[FT_QRST_BIT], irq_en: ftx_w[FT_IEN_BIT],
                         level: ftx_w[FT_LVL_MSB:0]};
      end
   end

   // ---------------- Transmit queue ----------------
   wire q_run     = ftx_reg.q_rst_n && ftx_reg.fifo_ena;
   wire push      = w_txq && q_run && (count_reg != CNT_W'(TXQ_DEPTH));
   wire pop       = (state_reg == SSTF_FETCH) && q_run;
   wire idle      = (state_reg == SSTF_IDLE) && ftx_reg.chan_rst_n;
   wire load_dir  = idle && (w_shift || (w_txq && !ftx_reg.fifo_ena));
   wire level_hit = ftx_reg.fifo_ena && (count_reg <= ftx_reg.level);

   sstf_txmem u_mem (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (push),
      .waddr   (wr_ptr_reg),
      .wdata   (w_data_reg),
      .raddr   (rd_ptr_reg),
      .rdata   (mem_rdata)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !ftx_reg.q_rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 4'h1;
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
         if (push && !pop)
            count_reg <= count_reg + 5'h1;
         else if (pop && !push)
            count_reg <= count_reg - 5'h1;
      end
   end

   // ---------------- Serial engine ----------------
   wire        slave_idle = idle && !ctrl_reg.master;
   wire        active     = (state_reg == SSTF_RUN) || slave_idle;
   wire        m_edge     = (state_reg == SSTF_RUN) && ctrl_reg.master &&
                            (div_reg == ctrl_reg.baud);
   wire        s_edge     = !ctrl_reg.master && (sclk_s != sclk_d_reg);
   wire        sc_edge    = active && !load_dir && (ctrl_reg.master ? m_edge : s_edge);
   wire        new_lvl    = ctrl_reg.master ? !sclk_o_reg : sclk_s;
   wire        lead       = new_lvl != ctrl_reg.cpol;
   wire        smp_edge   = sc_edge && (lead != ctrl_reg.cpha);
   wire        drv_edge   = sc_edge && (lead == ctrl_reg.cpha);
   wire        last_edge  = sc_edge && (edge_cnt_reg == {ctrl_reg.char_m1, 1'b1});

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !ftx_reg.chan_rst_n)
         state_reg <= SSTF_IDLE;
      else
      begin
         unique case (state_reg)
            SSTF_IDLE:
               if (load_dir && ctrl_reg.master)
                  state_reg <= SSTF_RUN;
               else if (slave_idle && sc_edge && !last_edge)
                  state_reg <= SSTF_RUN;
               else if (!load_dir && q_run && count_reg != 5'h0)
                  state_reg <= SSTF_FETCH;
            SSTF_FETCH:
               state_reg <= q_run ? SSTF_RUN : SSTF_IDLE;
            SSTF_RUN:
               if (last_edge)
                  state_reg <= SSTF_DONE;
            SSTF_DONE:
               state_reg <= SSTF_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         shift_reg    <= 16'h0;
         edge_cnt_reg <= 5'h0;
         sdo_reg      <= 1'b0;
      end
      else if (load_dir || pop)
      begin
         shift_reg    <= load_dir ? w_data_reg : mem_rdata;
         sdo_reg      <= load_dir ? w_data_reg[15] : mem_rdata[15];
         edge_cnt_reg <= 5'h0;
      end
      else if (!ftx_reg.chan_rst_n || state_reg == SSTF_DONE)
         edge_cnt_reg <= 5'h0;
      else if (sc_edge)
      begin
         edge_cnt_reg <= edge_cnt_reg + 5'h1;
         if (smp_edge)
            shift_reg <= {shift_reg[14:0], sdi_s};
         if (drv_edge)
            sdo_reg <= shift_reg[15];
      end
   end

   // Clock divider is free of the edge counter so half periods stay equal
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_reg     <= 8'h0;
         sclk_o_reg  <= 1'b0;
         sclk_oe_reg <= 1'b0;
         sclk_d_reg  <= 1'b0;
         sdo_oe_reg  <= 1'b0;
      end
      else
      begin
         sclk_d_reg  <= sclk_s;
         sclk_oe_reg <= ctrl_reg.master;
         sdo_oe_reg  <= ctrl_reg.transmit_drive_enable;
         if (state_reg != SSTF_RUN || !ctrl_reg.master)
         begin
            div_reg    <= 8'h0;
            sclk_o_reg <= ctrl_reg.cpol;
         end
         else if (m_edge)
         begin
            div_reg    <= 8'h0;
            sclk_o_reg <= !sclk_o_reg;
         end
         else
            div_reg <= div_reg + 8'h1;
      end
   end

   // ---------------- Flags and interrupts ----------------
   // A set in the same cycle as a clear wins so no event is lost
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_buf_reg  <= 16'h0;
         rx_flag_reg <= 1'b0;
         tx_flag_reg <= 1'b0;
         irq_reg     <= 1'b0;
         tx_irq_reg  <= 1'b0;
      end
      else
      begin
         if (state_reg == SSTF_DONE)
            rx_buf_reg <= shift_reg;
         if (state_reg == SSTF_DONE)
            rx_flag_reg <= 1'b1;
         else if (rd_rx || (w_stat && w_data_reg[ST_RX_BIT]))
            rx_flag_reg <= 1'b0;
         if (level_hit)
            tx_flag_reg <= 1'b1;
         else if ((w_ftx && ftx_w[FT_CLR_BIT]) || (w_stat && w_data_reg[ST_TX_BIT]))
            tx_flag_reg <= 1'b0;
         irq_reg    <= |({tx_flag_reg, rx_flag_reg} & mask_reg);
         tx_irq_reg <= tx_flag_reg && ftx_reg.irq_en;
      end
   end

   assign awready             = awready_reg;
   assign wready              = wready_reg;
   assign bvalid              = bvalid_reg;
   assign bresp               = bresp_reg;
   assign arready             = arready_reg;
   assign rvalid              = rvalid_reg;
   assign rdata               = rdata_reg;
   assign rresp               = rresp_reg;
   assign serial_clock_pin_o  = sclk_o_reg;
   assign serial_clock_pin_oe = sclk_oe_reg;
   assign serial_data_out     = sdo_reg;
   assign serial_data_out_oe  = sdo_oe_reg;
   assign irq                 = irq_reg;
   assign tx_queue_irq        = tx_irq_reg;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence fetch_seq;
      state_reg == SSTF_FETCH && q_run ##1 state_reg == SSTF_RUN;
   endsequence

   sequence done_seq;
      state_reg == SSTF_RUN && last_edge ##1 state_reg == SSTF_DONE;
   endsequence

   msb_first_a: assert property (load_dir |=> sdo_reg == $past(w_data_reg[15]))
      else $error("first bit out is not the written msb");
   shift_in_a: assert property (smp_edge && !load_dir && ftx_reg.chan_rst_n
      |=> shift_reg == {$past(shift_reg[14:0]), $past(sdi_s)})
      else $error("received bit did not enter at bit zero");
   transmit_drive_enable_gate_a: assert property (!ctrl_reg.transmit_drive_enable |=> !serial_data_out_oe)
      else $error("serial output driven with transmit_drive_enable clear");
   master_start_a: assert property (load_dir && ctrl_reg.master
      |=> state_reg == SSTF_RUN ##1 !serial_clock_pin_o == !ctrl_reg.cpol)
      else $error("master write did not start a transfer");
   chan_reset_a: assert property (!ftx_reg.chan_rst_n && !w_ftx
      |=> state_reg == SSTF_IDLE && $stable(ftx_reg))
      else $error("channel reset did not hold engine or lost config");
   fifo_off_a: assert property (!ftx_reg.fifo_ena && ftx_reg.q_rst_n
      |=> $stable(count_reg) && !tx_flag_reg || $past(tx_flag_reg))
      else $error("queue moved while disabled");
   qreset_a: assert property (!ftx_reg.q_rst_n |=> count_reg == 5'h0)
      else $error("queue reset did not clear count");
   count_up_a: assert property (push && !pop
      |=> count_reg == $past(count_reg) + 5'h1)
      else $error("queue count did not follow a push");
   fetch_pop_a: assert property (fetch_seq |-> shift_reg == $past(mem_rdata))
      else $error("fetched word not loaded");
   level_set_a: assert property (level_hit |=> tx_flag_reg ##1 (tx_flag_reg ||
      $past(w_ftx && ftx_w[FT_CLR_BIT] || w_stat && w_data_reg[ST_TX_BIT])))
      else $error("level match did not set flag");
   clear_one_a: assert property (w_ftx && ftx_w[FT_CLR_BIT] && !level_hit
      |=> !tx_flag_reg)
      else $error("clear bit did not clear flag");
   txirq_out_a: assert property (##1 tx_queue_irq
      == $past(tx_flag_reg && ftx_reg.irq_en))
      else $error("queue interrupt output mismatch");
   rx_copy_a: assert property (done_seq
      |=> rx_buf_reg == $past(shift_reg) && rx_flag_reg)
      else $error("character not copied to receive buffer");
endmodule

// >>> include/sstf_pkg.sv
// Constants, field layouts and carrier types of the serial shift register block
package sstf_pkg;
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned TXQ_DEPTH = 16;
   localparam int unsigned TXQ_AW    = 4;
   localparam int unsigned CNT_W     = 5;
   localparam int unsigned EVT_W     = 2;

   // Register indices; byte address is four times the index
   localparam logic [15:0] RXBUF_IDX      = 16'h7047;
   localparam logic [15:0] TXQ_IDX        = 16'h7048;
   localparam logic [15:0] SHIFT_DATA_IDX = 16'h7049;
   localparam logic [15:0] FIFO_CTRL_IDX  = 16'h704a;
   localparam logic [15:0] CTRL_IDX       = 16'h7041;
   localparam logic [15:0] STAT_IDX       = 16'h7050;
   localparam logic [15:0] MASK_IDX       = 16'h7051;

   // fifo_transmit_control field positions
   localparam int unsigned FT_CHRST_BIT = 15;
   localparam int unsigned FT_ENA_BIT   = 14;
   localparam int unsigned FT_QRST_BIT  = 13;
   localparam int unsigned FT_CNT_LSB   = 8;
   localparam int unsigned FT_FLAG_BIT  = 7;
   localparam int unsigned FT_CLR_BIT   = 6;
   localparam int unsigned FT_IEN_BIT   = 5;
   localparam int unsigned FT_LVL_MSB   = 4;

   // Event status bits
   localparam int unsigned ST_RX_BIT = 0;
   localparam int unsigned ST_TX_BIT = 1;

   localparam logic [15:0] CTRL_RESET = 16'h03f0;
   localparam logic [15:0] FT_RESET   = 16'ha000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   typedef struct packed {
      logic [7:0] baud;
      logic [3:0] char_m1;
      logic       cpha;
      logic       cpol;
      logic       transmit_drive_enable;
      logic       master;
   } sstf_ctrl_s;

   typedef struct packed {
      logic       chan_rst_n;
      logic       fifo_ena;
      logic       q_rst_n;
      logic       irq_en;
      logic [4:0] level;
   } sstf_ftx_s;

   typedef enum logic [1:0] {SSTF_IDLE, SSTF_FETCH, SSTF_RUN, SSTF_DONE} sstf_state_e;

   function automatic logic sstf_hit(input logic [31:0] a, input logic [15:0] idx);
      return a == {14'h0, idx, 2'b00};
   endfunction

   function automatic logic [15:0] sstf_merge(input logic [15:0] old,
                                              input logic [15:0] nw,
                                              input logic [1:0]  strb);
      return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction
endpackage

// >>> hw/sstf_sync.sv
// Two-flop synchroniser for the serial clock and data pins
`timescale 1ns/10ps
module sstf_sync (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] d,
   output logic [1:0]      q
);
   logic [1:0] meta_reg;
   logic [1:0] q_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_reg <= 2'h0;
         q_reg    <= 2'h0;
      end
      else
      begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule

// >>> hw/sstf_txmem.sv
// Transmit queue storage with registered read data
`timescale 1ns/10ps
module sstf_txmem
   import sstf_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              we,
   input  wire logic [TXQ_AW-1:0] waddr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [TXQ_AW-1:0] raddr,
   output logic [DATA_W-1:0]      rdata
);
   logic [DATA_W-1:0] mem_reg [TXQ_DEPTH];
   logic [DATA_W-1:0] rdata_reg;

   always_ff @(posedge aclk)
   begin
      if (we)
         mem_reg[waddr] <= wdata;
   end

   // Old contents on a same-edge write; the reader waits a cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rdata_reg <= 16'h0;
      else
         rdata_reg <= mem_reg[raddr];
   end

   assign rdata = rdata_reg;
endmodule

// >>> verif/sstf_peer.sv
// Behavioural serial peer on the far side of the link, samples on rise (modes 0 and 3)
`timescale 1ns/10ps
module sstf_peer (
   input  wire logic        aclk,
   input  wire logic        sclk,
   input  wire logic        sdo,
   input  wire logic        load,
   input  wire logic [15:0] word,
   output logic             sdi,
   output logic [15:0]      cap
);
   logic        sclk_q;
   logic        tgl = 1'b0;
   logic [15:0] sh;
   logic [4:0]  n = 5'h10;
   always_ff @(posedge aclk)
   begin
      sclk_q <= sclk;
      tgl    <= ~tgl;
      if (load)
      begin
         sh <= word;
         n  <= 5'h00;
      end
      else if (sclk && !sclk_q)
      begin
         cap <= {cap[14:0], sdo};
         n   <= n + 5'h01;
      end
      // A fall before the first rise of a frame is the mode 3 leading edge
      else if (!sclk && sclk_q && n != 5'h00)
         sh <= {sh[14:0], 1'b0};
   end
   // Nobody holds the line outside a frame, so it must not look stable
   assign sdi = (n < 5'h10) ? sh[15] : tgl;
endmodule

// >>> verif/spi_shift_reg_tx_fifo_ctrl_test.sv
// Self-checking bench: register bus, serial transfers and transmit queue control
`timescale 1ns/10ps
module spi_shift_reg_tx_fifo_ctrl_test;
   import sstf_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, tx_queue_irq;
   logic [1:0]  bresp, rresp, r;
   logic        sck_o, sck_oe, sdo, sdo_oe, sdi, pload = 1'b0;
   logic [15:0] pword = 16'h0, cap, d, w, m;
   logic [31:0] seed = 32'ha322c1de;
   int          n_mismatch = 0, compares = 0;
   wire         sclk = sck_oe & sck_o;
   sstf_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h3), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .serial_clock_pin_i(sclk),
      .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe), .serial_data_in(sdi),
      .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .irq(irq),
      .tx_queue_irq(tx_queue_irq));
   sstf_peer u_peer (.aclk(aclk), .sclk(sclk), .sdo(sdo_oe & sdo), .load(pload),
      .word(pword), .sdi(sdi), .cap(cap));
   initial
   begin
      forever #20 aclk = ~aclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [15:0] ftx(input logic [2:0] top, input logic [4:0] cnt,
                                       input logic fl, input logic ie, input logic [4:0] lv);
      return {top, cnt, fl, 1'b0, ie, lv};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [15:0] v);
      logic a, b;
      a = 1'b0;
      b = 1'b0;
      awaddr  <= {14'h0, idx, 2'b00};
      wdata   <= {16'h0, v};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(a && b))
      begin
         @(posedge aclk);
         if (awvalid && awready)
         begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            b = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
   endtask
   task automatic rd(input logic [15:0] idx, output logic [15:0] v);
      araddr  <= {14'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      v = rdata[15:0];
      r = rresp;
   endtask
   task automatic peer_load(input logic [15:0] v);
      pword <= v;
      pload <= 1'b1;
      @(posedge aclk);
      pload <= 1'b0;
   endtask
   task automatic wait_rx();
      repeat (80)
      begin
         rd(STAT_IDX, d);
         if (d[ST_RX_BIT])
            break;
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      end_sim();
   end
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(FIFO_CTRL_IDX, d);
      chk(d, ftx(3'b101, 5'h0, 1'b0, 1'b0, 5'h0), "ftx reset");
      rd(16'h7000, d);
      chk(r, RESP_DECERR, "unmapped");
      wr(CTRL_IDX, 16'h03f3);
      wr(MASK_IDX, 16'h0001);
      chk(sdo_oe, 1'b1, "drive on");
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         w = (i == 0) ? 16'h0000 : seed[15:0];
         m = (i == 1) ? 16'h00ff : 16'hffff;
         // Mode 0, then an 8-bit character, then mode 3 (the peer samples on rise)
         wr(CTRL_IDX, (i == 1) ? 16'h0373 : (i < 2) ? 16'h03f3 : 16'h03ff);
         peer_load(seed[31:16]);
         wr(SHIFT_DATA_IDX, w);
         wait_rx();
         chk(irq, 1'b1, "irq up");
         chk(cap & m, (i == 1) ? {8'h0, w[15:8]} : w, "peer got");
         rd(RXBUF_IDX, d);
         chk(d & m, (i == 1) ? {8'h0, seed[31:24]} : seed[31:16], "rx word");
         wr(STAT_IDX, 16'h0001);
         repeat (2) @(posedge aclk);
         chk(irq, 1'b0, "irq clear");
      end
      $display("test transfer done");
      wr(FIFO_CTRL_IDX, 16'h6020);
      repeat (2) @(posedge aclk);
      chk(tx_queue_irq, 1'b1, "txq irq");
      rd(FIFO_CTRL_IDX, d);
      chk(d, ftx(3'b011, 5'h0, 1'b1, 1'b1, 5'h0), "flag set");
      repeat (3) wr(TXQ_IDX, seed[15:0]);
      rd(FIFO_CTRL_IDX, d);
      chk(d, ftx(3'b011, 5'h3, 1'b1, 1'b1, 5'h0), "count");
      wr(FIFO_CTRL_IDX, 16'h6062);
      rd(FIFO_CTRL_IDX, d);
      chk(d, ftx(3'b011, 5'h3, 1'b0, 1'b1, 5'h2), "cleared");
      chk(tx_queue_irq, 1'b0, "txq low");
      wr(FIFO_CTRL_IDX, 16'h4022);
      // Count clears one cycle after the write, the flag one cycle later
      repeat (2) @(posedge aclk);
      rd(FIFO_CTRL_IDX, d);
      chk(d, ftx(3'b010, 5'h0, 1'b1, 1'b1, 5'h2), "queue reset");
      wr(FIFO_CTRL_IDX, 16'h4002);
      repeat (2) @(posedge aclk);
      chk(tx_queue_irq, 1'b0, "gated");
      peer_load(seed[31:16]);
      wr(FIFO_CTRL_IDX, 16'he002);
      wr(TXQ_IDX, seed[15:0]);
      wait_rx();
      chk(cap, seed[15:0], "queued word out");
      rd(RXBUF_IDX, d);
      chk(d, seed[31:16], "queued word in");
      wr(CTRL_IDX, 16'h03f1);
      repeat (2) @(posedge aclk);
      chk(sdo_oe, 1'b0, "drive off");
      $display("test queue done");
      end_sim();
   end
endmodule
